/* File: shared/sdr_pkg.sv */
// Purpose: Shared constants and types for the SDRAM bank, row and read-burst block
// Assumes: Command pins follow the usual chip-select, row, column and write-enable code
// Notes:   Every address bit position, command code and register offset of the block lives here

package sdr_pkg;

  // Pin group widths
  localparam int unsigned BA_W     = 3;
  localparam int unsigned ADDR_W   = 15;
  localparam int unsigned COL_W    = 10;
  localparam int unsigned DQ_W     = 16;
  localparam int unsigned NBANK    = 8;
  localparam int unsigned CMD_W    = 4 + BA_W + ADDR_W;

  // Command codes on {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ  = 4'h5;

  // Pin levels held by the synchroniser during reset (chip deselected)
  localparam logic [CMD_W:0] PINS_IDLE = 23'h780000;

  // Address bit positions
  localparam int unsigned A_AP     = 10;  // Auto precharge / all banks
  localparam int unsigned A_BC     = 12;  // Burst length on the fly
  localparam int unsigned MR0_BL   = 0;   // Two-bit burst length field
  localparam int unsigned MR0_CL   = 4;   // Three-bit CAS latency field
  localparam int unsigned MR1_AL   = 3;   // Two-bit additive latency field
  localparam int unsigned MR2_ASR  = 6;
  localparam int unsigned MR2_SRT  = 7;

  // Mode register selects on the bank address pins
  localparam logic [BA_W-1:0] MR_SEL0 = 3'h0;
  localparam logic [BA_W-1:0] MR_SEL1 = 3'h1;
  localparam logic [BA_W-1:0] MR_SEL2 = 3'h2;

  // Burst length modes
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;

  // Additive latency selects
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CLM1 = 2'h1;
  localparam logic [1:0] AL_CLM2 = 2'h2;

  // Latency arithmetic
  localparam int unsigned LAT_W    = 5;
  localparam logic [LAT_W-1:0] CL_BASE = 5'h04;
  localparam logic [LAT_W-1:0] LAT_ONE = 5'h01;
  localparam logic [LAT_W-1:0] LAT_TWO = 5'h02;

  // Data edges per burst, two per clock
  localparam logic [3:0] EDGES_BL8 = 4'h8;
  localparam logic [3:0] EDGES_BC4 = 4'h4;

  // Register offsets
  localparam logic [7:0] REG_PATTERN = 8'h00;
  localparam logic [7:0] REG_ERROR   = 8'h04;
  localparam logic [7:0] REG_MODE    = 8'h08;
  localparam logic [7:0] REG_BANKS   = 8'h0c;

  // Error flag positions
  localparam int unsigned ERR_COL_IDLE = 0;
  localparam int unsigned ERR_MR2_BAD  = 1;
  localparam int unsigned ERR_ACT_BUSY = 2;
  localparam int unsigned ERR_W        = 3;

  // Bank states
  typedef enum logic [1:0] {
    BK_IDLE,
    BK_ACTIVE,
    BK_PRECH
  } sdr_bank_st_t;

  // Self-refresh rate selection
  typedef enum logic [1:0] {
    SR_NORMAL,
    SR_EXTENDED,
    SR_AUTO
  } sdr_sr_t;

  // Command and address pins as sampled
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] a;
  } sdr_cmd_t;

  // One pending read
  typedef struct packed {
    logic             vld;
    logic             bc4;
    logic [BA_W-1:0]  ba;
    logic [COL_W-1:0] col;
  } sdr_rd_t;

endpackage

/* File: logic/sdr_sync.sv */
// Purpose: Two-flop synchroniser for pins sampled from outside the clock domain
// Assumes: Multi-bit groups are stable around the edge on which they are used
// Notes:   The first stage feeds only the second stage

`timescale 1ns/1ps

module sdr_sync #(
  parameter int unsigned   W       = 1,
  parameter logic [W-1:0]  RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Pins in, synchronised copy out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;

  // Two-stage capture
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      o_q    <= RST_VAL;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end

endmodule

/* File: logic/sdr_bank.sv */
// Purpose: State of one bank: idle, open with its row, or precharging
// Assumes: i_tick marks each rising edge of the memory clock
// Notes:   Every precharge restarts the precharge timer

`timescale 1ns/1ps

module sdr_bank import sdr_pkg::*; #(
  parameter int unsigned TRP_NCK = 5,
  parameter int unsigned ROW_W   = 15
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // Commands to this bank
  input  wire logic             i_tick,
  input  wire logic             i_act,
  input  wire logic             i_pre,
  input  wire logic [ROW_W-1:0] i_row,
  // Bank state
  output sdr_bank_st_t          o_state,
  output logic      [ROW_W-1:0] o_row
);

  localparam int unsigned CNT_W = $clog2(TRP_NCK + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(TRP_NCK - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  logic [CNT_W-1:0] cnt_q;

  // Open, close and time the precharge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_state <= BK_IDLE;
      o_row   <= '0;
      cnt_q   <= CNT_ZERO;
    end else if (i_pre) begin
      o_state <= BK_PRECH;
      cnt_q   <= CNT_LOAD;
    end else if (i_act && o_state == BK_IDLE) begin
      o_state <= BK_ACTIVE;
      o_row   <= i_row;
    end else if (i_tick && o_state == BK_PRECH) begin
      if (cnt_q == CNT_ZERO) begin
        o_state <= BK_IDLE;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

/* File: logic/sdr_core.sv */
// Purpose: Device-side command logic of an eight-bank DDR SDRAM: modes, rows, read bursts
// Assumes: Command pins are stable around each rising edge of the memory clock
// Notes:   Memory clock is sampled by i_clk and its edges found after two flops
//
// Overview of operation
// - Temperature bit 0 selects a self-refresh rate for normal range only.
// - Temperature bit 1 selects a rate covering normal and extended ranges.
// - Mode 2 bit 6 set, bit 7 clear is auto mode; both set is illegal.
// - ACTIVE opens the addressed row in the bank chosen by bank pins.
// - An open row stays open until a PRECHARGE reaches its bank.
// - PRECHARGE closes one selected bank or all banks together.
// - PRECHARGE to an idle or precharging bank is legal.
// - Precharge time runs from the latest PRECHARGE to the bank.
// - On the fly, address bit 12 low gives four beats, high eight.
// - Address bit 12 never forms part of the column address.
// - Burst field 00 fixes eight beats, 01 selects by bit 12.
// - Read latency is additive latency plus CAS latency.
// - Strobe driven from latency minus one, data from the latency edge.
// - Drivers stop at latency plus four, or plus two when chopped.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.

`timescale 1ns/1ps

module sdr_core import sdr_pkg::*; #(
  parameter int unsigned TRP_NCK = 5,
  parameter int unsigned RL_MAX  = 32
) (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  // Memory link from the controller
  input  wire logic              i_ck,
  input  wire sdr_cmd_t          i_cmd,
  // Read data and strobe drivers
  output logic      [DQ_W-1:0]   o_dq,
  output logic                   o_dq_oe,
  output logic                   o_dqs,
  output logic                   o_dqs_oe,
  // Self-refresh rate in force
  output sdr_sr_t                o_sr_mode,
  // Register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata
);

  // Synchronised pins and memory clock edges
  logic [CMD_W:0] pins_s;
  logic           ck_s;
  logic           ck_q;
  logic           ck_rise;
  logic           ck_fall;
  sdr_cmd_t       cmd;
  logic [3:0]     code;

  // Pins and memory clock share one synchroniser, so a command is always
  // seen in the same i_clk cycle as the clock edge that qualifies it
  sdr_sync #(
    .W       (CMD_W + 1),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_cmd, i_ck}),
    .o_q     (pins_s)
  );

  assign ck_s = pins_s[0];
  assign cmd  = sdr_cmd_t'(pins_s[CMD_W:1]);
  assign code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};

  // Edge finder on the synchronised clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ck_s;
    end
  end

  assign ck_rise = ck_s & ~ck_q;
  assign ck_fall = ~ck_s & ck_q;

  // Command decode on each rising memory clock edge
  logic is_act;
  logic is_pre;
  logic is_read;
  logic is_write;
  logic is_col;
  logic is_mrs;

  assign is_act   = ck_rise && code == CMD_ACT;
  assign is_pre   = ck_rise && code == CMD_PRE;
  assign is_read  = ck_rise && code == CMD_READ;
  assign is_write = ck_rise && code == CMD_WRITE;
  assign is_col   = is_read | is_write;
  assign is_mrs   = ck_rise && code == CMD_MRS;

  // Mode register fields
  logic [1:0] bl_mode_q;
  logic [2:0] cl_fld_q;
  logic [1:0] al_sel_q;
  logic       asr_q;
  logic       srt_q;
  logic       mr2_bad;

  assign mr2_bad = cmd.a[MR2_ASR] & cmd.a[MR2_SRT];

  // Mode register loads; an illegal mode 2 setting is refused
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bl_mode_q <= BL_FIX8;
      cl_fld_q  <= '0;
      al_sel_q  <= AL_ZERO;
      asr_q     <= 1'b0;
      srt_q     <= 1'b0;
    end else if (is_mrs && cmd.ba == MR_SEL0) begin
      bl_mode_q <= cmd.a[MR0_BL +: 2];
      cl_fld_q  <= cmd.a[MR0_CL +: 3];
    end else if (is_mrs && cmd.ba == MR_SEL1) begin
      al_sel_q  <= cmd.a[MR1_AL +: 2];
    end else if (is_mrs && cmd.ba == MR_SEL2 && !mr2_bad) begin
      asr_q     <= cmd.a[MR2_ASR];
      srt_q     <= cmd.a[MR2_SRT];
    end
  end

  // Latency arithmetic
  logic [LAT_W-1:0] cl_w;
  logic [LAT_W-1:0] al_w;
  logic [LAT_W-1:0] rl_w;

  assign cl_w = LAT_W'(cl_fld_q) + CL_BASE;
  assign al_w = (al_sel_q == AL_CLM1) ? cl_w - LAT_ONE :
                (al_sel_q == AL_CLM2) ? cl_w - LAT_TWO : '0;
  assign rl_w = al_w + cl_w;

  // Self-refresh rate choice
  sdr_sr_t sr_d;

  assign sr_d = asr_q ? SR_AUTO :
                srt_q ? SR_EXTENDED :
                SR_NORMAL;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sr_mode <= SR_NORMAL;
    end else begin
      o_sr_mode <= sr_d;
    end
  end

  // Banks
  sdr_bank_st_t              bk_state [NBANK];
  logic [ADDR_W-1:0]         bk_row   [NBANK];
  logic [NBANK-1:0]          bk_open;
  logic [2*NBANK-1:0]        bk_flat;

  for (genvar g = 0; g < NBANK; g++) begin : g_bank
    logic hit;
    logic pre_g;
    logic ap_g;

    assign hit   = cmd.ba == BA_W'(g);
    assign pre_g = is_pre && (cmd.a[A_AP] || hit);
    assign ap_g  = is_col && cmd.a[A_AP] && hit && bk_open[g];

    sdr_bank #(
      .TRP_NCK (TRP_NCK),
      .ROW_W   (ADDR_W)
    ) u_bank (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_tick  (ck_rise),
      .i_act   (is_act && hit),
      .i_pre   (pre_g | ap_g),
      .i_row   (cmd.a),
      .o_state (bk_state[g]),
      .o_row   (bk_row[g])
    );

    assign bk_open[g]          = bk_state[g] == BK_ACTIVE;
    assign bk_flat[2*g +: 2]   = bk_state[g];
  end

  // Burst length and column selection
  logic             bc4_w;
  logic [COL_W-1:0] col_w;
  logic             col_ok;
  sdr_rd_t          new_rd;

  assign bc4_w  = (bl_mode_q == BL_OTF) ? ~cmd.a[A_BC] :
                  (bl_mode_q == BL_FIX4);
  assign col_w  = cmd.a[COL_W-1:0];
  assign col_ok = bk_open[cmd.ba];
  assign new_rd = '{vld: is_read && col_ok, bc4: bc4_w, ba: cmd.ba, col: col_w};

  // Read latency pipeline, one stage per memory clock
  // A latency change with reads in flight moves their data slot, so the
  // controller must let the pipe drain before loading new latencies
  sdr_rd_t rd_pipe_q [RL_MAX];
  sdr_rd_t at_pre;
  sdr_rd_t at_start;

  assign at_pre   = rd_pipe_q[rl_w - LAT_TWO];
  assign at_start = rd_pipe_q[rl_w - LAT_ONE];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < RL_MAX; i++) begin
        rd_pipe_q[i] <= '0;
      end
    end else if (ck_rise) begin
      rd_pipe_q[0] <= new_rd;
      for (int i = 1; i < RL_MAX; i++) begin
        rd_pipe_q[i] <= rd_pipe_q[i-1];
      end
    end
  end

  // Burst engine state
  sdr_rd_t    cur_q;
  logic [2:0] beat_q;
  logic [3:0] left_q;
  logic       busy;
  logic [DQ_W-1:0] pattern_q;

  assign busy = left_q != '0;

  // Beat value from bank, column and beat number, scrambled by the pattern
  function automatic logic [DQ_W-1:0] beat_data(input sdr_rd_t d, input logic [2:0] b,
                                                input logic [DQ_W-1:0] pat);
    logic [COL_W-1:0] c;
    c = d.col + COL_W'(b);
    return pat ^ {d.ba, c, b};
  endfunction

  // Strobe and data drivers, two beats per memory clock
  // A burst that starts while another is busy takes over at once; with
  // four-clock spacing this gives seamless back-to-back eight-beat bursts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_q    <= '0;
      beat_q   <= '0;
      left_q   <= '0;
      o_dq     <= '0;
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
    end else if (ck_rise && at_start.vld) begin
      cur_q    <= at_start;
      o_dq     <= beat_data(at_start, '0, pattern_q);
      beat_q   <= 3'h1;
      left_q   <= (at_start.bc4 ? EDGES_BC4 : EDGES_BL8) - 1'b1;
      o_dq_oe  <= 1'b1;
      o_dqs    <= 1'b1;
      o_dqs_oe <= 1'b1;
    end else if ((ck_rise || ck_fall) && busy) begin
      o_dq     <= beat_data(cur_q, beat_q, pattern_q);
      beat_q   <= beat_q + 1'b1;
      left_q   <= left_q - 1'b1;
      o_dqs    <= ck_rise;
    end else if (ck_rise && at_pre.vld) begin
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b1;
    end else if (ck_rise) begin
      o_dq_oe  <= 1'b0;
      o_dqs    <= 1'b0;
      o_dqs_oe <= 1'b0;
    end else if (ck_fall) begin
      o_dqs    <= 1'b0;
    end
  end

  // Error events seen on the command pins
  logic [ERR_W-1:0] err_set;
  logic [ERR_W-1:0] err_q;
  logic [ERR_W-1:0] err_clr;

  assign err_set[ERR_COL_IDLE] = is_col && !col_ok;
  assign err_set[ERR_MR2_BAD]  = is_mrs && cmd.ba == MR_SEL2 && mr2_bad;
  assign err_set[ERR_ACT_BUSY] = is_act && bk_state[cmd.ba] != BK_IDLE;

  // Register decode
  logic wr_pattern;
  logic wr_error;

  assign wr_pattern = i_wr && i_addr == REG_PATTERN;
  assign wr_error   = i_wr && i_addr == REG_ERROR;
  assign err_clr    = wr_error ? i_wdata[ERR_W-1:0] : '0;

  // Sticky errors, a new event wins over a clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q <= '0;
    end else begin
      err_q <= (err_q & ~err_clr) | err_set;
    end
  end

  // Data pattern register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pattern_q <= '0;
    end else if (wr_pattern) begin
      pattern_q <= i_wdata[DQ_W-1:0];
    end
  end

  // Read mux
  logic [31:0] mode_word;
  logic [31:0] rd_mux;

  // Mode word: burst field [1:0], additive select [3:2], additive latency [8:4],
  // read latency [16:12], self-refresh rate [21:20]
  assign mode_word = {10'h000, o_sr_mode, 3'h0, rl_w, 3'h0, al_w,
                      al_sel_q, bl_mode_q};
  assign rd_mux = (i_addr == REG_PATTERN) ? {16'h0000, pattern_q} :
                  (i_addr == REG_ERROR)   ? {29'h00000000, err_q} :
                  (i_addr == REG_MODE)    ? mode_word :
                  (i_addr == REG_BANKS)   ? {16'h0000, bk_flat} : '0;

  // Read data stand for one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rd_mux : '0;
    end
  end

endmodule

/* File: verification/sdr_core_sva.sv */
// Purpose: Concurrent checks on read drivers and self-refresh rate of the core
// Assumes: Command pins hold for a whole memory clock around each rising edge
// Notes:   Sees only core ports; attached by the bind below the module
`timescale 1ns/1ps

module sdr_core_chk import sdr_pkg::*; (
  // Clock and reset
  input wire logic            i_clk,
  input wire logic            i_rst_n,
  // Link pins and read drivers
  input wire sdr_cmd_t        i_cmd,
  input wire logic [DQ_W-1:0] o_dq,
  input wire logic            o_dq_oe,
  input wire logic            o_dqs,
  input wire logic            o_dqs_oe,
  input wire sdr_sr_t         o_sr_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Pin decode of mode-2 loads and reads
  wire logic [3:0] code_pins = {i_cmd.cs_n, i_cmd.ras_n, i_cmd.cas_n, i_cmd.we_n};
  wire logic       mr2_pins  = (code_pins == CMD_MRS) && (i_cmd.ba == MR_SEL2);
  wire logic       rd_pins   = (code_pins == CMD_READ);
  logic [3:0] mr2_age_q;
  logic [1:0] mr2_bits_q;
  logic [9:0] rd_age_q;
  logic [7:0] on_cnt_q;

  // Ages since the last mode-2 load and read, length of the data window
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mr2_age_q  <= 4'hf;
      mr2_bits_q <= 2'h0;
      rd_age_q   <= 10'h3ff;
      on_cnt_q   <= 8'h00;
    end else begin
      mr2_age_q  <= mr2_pins ? 4'h0 : mr2_age_q + 4'(mr2_age_q != 4'hf);
      mr2_bits_q <= mr2_pins ? i_cmd.a[MR2_SRT:MR2_ASR] : mr2_bits_q;
      rd_age_q   <= rd_pins ? 10'h0 : rd_age_q + 10'(rd_age_q != 10'h3ff);
      on_cnt_q   <= o_dq_oe ? on_cnt_q + 8'(on_cnt_q != 8'hff) : 8'h00;
    end
  end

  property p_pre_low; o_dqs_oe && !o_dq_oe |-> !o_dqs; endproperty
  a_pre_low: assert property (p_pre_low) else $error("strobe high in preamble");
  property p_pre_first; $rose(o_dq_oe) |-> $past(o_dqs_oe, 8) && !$past(o_dq_oe, 8); endproperty
  a_pre_first: assert property (p_pre_first) else $error("data without preamble");
  property p_off_same; $fell(o_dqs_oe) |-> $fell(o_dq_oe); endproperty
  a_off_same: assert property (p_off_same) else $error("drivers not off together");
  property p_beat_edge; o_dq_oe && $past(o_dq_oe) && $changed(o_dq) |-> $changed(o_dqs);
  endproperty
  a_beat_edge: assert property (p_beat_edge) else $error("beat without strobe edge");
  property p_len; $fell(o_dq_oe) |-> on_cnt_q >= 8'd47; endproperty
  a_len: assert property (p_len) else $error("data window too short");
  property p_half; $rose(o_dqs) |-> o_dqs [*8]; endproperty
  a_half: assert property (p_half) else $error("strobe high too short");
  property p_rd_cause; $rose(o_dqs_oe) |-> rd_age_q >= 10'd50 && rd_age_q < 10'd1000;
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("strobe not after read");
  property p_sr_cause; $changed(o_sr_mode) |-> mr2_age_q < 4'd15 && mr2_bits_q != 2'b11;
  endproperty
  a_sr_cause: assert property (p_sr_cause) else $error("rate changed without load");
  property p_sr_val; $changed(o_sr_mode) |-> o_sr_mode == (mr2_bits_q == 2'b01 ? SR_AUTO
    : (mr2_bits_q == 2'b10 ? SR_EXTENDED : SR_NORMAL)); endproperty
  a_sr_val: assert property (p_sr_val) else $error("wrong self-refresh rate");
endmodule

bind sdr_core sdr_core_chk i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd(i_cmd),
  .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .o_sr_mode(o_sr_mode));

/* File: verification/sdr_ctl_model.sv */
// Purpose: Behavioural memory controller driving the memory clock and command pins
// Assumes: Commands launch on a clock fall and hold for one full clock
// Notes:   Deselected pins show inverted values so stale commands never linger
`timescale 1ns/1ps

module sdr_ctl_model import sdr_pkg::*; (
  // Memory link
  output logic     o_ck,
  output sdr_cmd_t o_cmd
);
  // Free-running clock, offset so its edges never meet the system clock
  initial begin
    o_ck = 1'b0;
    o_cmd = '1;
    #1.3;
    forever #62.5 o_ck = ~o_ck;
  end

  // One command, stable across the rising edge that takes it
  task issue(input logic [3:0] code, input logic [BA_W-1:0] ba, input logic [ADDR_W-1:0] a);
    @(negedge o_ck);
    o_cmd <= {code, ba, a};
    @(negedge o_ck);
    o_cmd <= {1'b1, ~code[2:0], ~ba, ~a};
  endtask
endmodule

/* File: verification/test_sdr_bank_row_read_burst.sv */
// Purpose: Self-checking bench for mode loads, bank states and read bursts
// Assumes: Pattern register set to a55a before any burst
// Notes:   Strobe and data are sampled mid-way through each memory half clock
`timescale 1ns/1ps

module test_sdr_bank_row_read_burst import sdr_pkg::*; ;
  // Bench signals
  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [31:0]     rdata;
  logic            ck;
  sdr_cmd_t        cmd;
  logic [DQ_W-1:0] dq;
  logic            dq_oe;
  logic            dqs;
  logic            dqs_oe;
  sdr_sr_t         sr_mode;
  int              n_fail = 0;
  int              compares = 0;
  sdr_sr_t         sr_exp [4] = '{SR_NORMAL, SR_AUTO, SR_EXTENDED, SR_EXTENDED};

  always #2.5 clk = ~clk;

  sdr_core #(.TRP_NCK(5), .RL_MAX(32)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ck(ck),
    .i_cmd(cmd), .o_dq(dq), .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe),
    .o_sr_mode(sr_mode), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata));
  sdr_ctl_model i_ctl (.o_ck(ck), .o_cmd(cmd));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task reg_wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task reg_rd(input logic [7:0] ad, input logic [31:0] exp);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task wait_ck(input int n);
    repeat (n) @(negedge ck);
  endtask

  // One read, then strobe and data checked in every half clock
  task rd_burst(input logic [2:0] b, input logic [9:0] col, input logic a12, input int nck,
                input int rl);
    logic [31:0] e;
    logic [9:0]  c;
    logic        on;
    logic        pre;
    int          k;
    i_ctl.issue(CMD_READ, b, {2'b00, a12, 2'b00, col});
    for (int h = 1; h < 2 * (rl + 6); h++) begin
      #30;
      k = h - 2 * rl;
      on = (k >= 0) && (k < 2 * nck);
      pre = (h >= 2 * rl - 2) && (k < 2 * nck);
      c = col + 10'(k);
      e = {13'h0, pre, on, on & ~h[0], on ? (16'ha55a ^ {b, c, 3'(k)}) : 16'h0};
      check({13'h0, dqs_oe, dq_oe, dqs & pre, dq & {DQ_W{on}}}, e);
      @(ck);
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    reg_rd(REG_ERROR, 32'h0);
    reg_rd(REG_BANKS, 32'h0);
    reg_rd(8'h10, 32'h0);
    reg_wr(REG_PATTERN, 32'h0000a55a);
    reg_rd(REG_PATTERN, 32'h0000a55a);
    for (int i = 0; i < 4; i++) begin
      i_ctl.issue(CMD_MRS, MR_SEL2, 15'(i) << MR2_ASR);
      check({30'h0, sr_mode}, {30'h0, sr_exp[i]});
    end
    reg_rd(REG_ERROR, 32'h2);
    reg_wr(REG_ERROR, 32'h2);
    i_ctl.issue(CMD_MRS, MR_SEL0, 15'h0011);
    i_ctl.issue(CMD_MRS, MR_SEL1, 15'h0000);
    reg_rd(REG_MODE, 32'h00105001);
    i_ctl.issue(CMD_ACT, 3'h3, 15'h1abc);
    reg_rd(REG_BANKS, 32'h40);
    i_ctl.issue(CMD_ACT, 3'h3, 15'h0111);
    reg_rd(REG_ERROR, 32'h4);
    reg_wr(REG_ERROR, 32'h4);
    rd_burst(3'h3, 10'h010, 1'b1, 4, 5);
    rd_burst(3'h3, 10'h025, 1'b0, 2, 5);
    i_ctl.issue(CMD_MRS, MR_SEL1, 15'h0008);
    rd_burst(3'h3, 10'h040, 1'b1, 4, 9);
    i_ctl.issue(CMD_MRS, MR_SEL0, 15'h0010);
    rd_burst(3'h3, 10'h050, 1'b0, 4, 9);
    i_ctl.issue(CMD_MRS, MR_SEL0, 15'h0012);
    rd_burst(3'h3, 10'h058, 1'b1, 2, 9);
    i_ctl.issue(CMD_READ, 3'h5, 15'h0);
    wait_ck(12);
    check({31'h0, dq_oe}, 32'h0);
    reg_rd(REG_ERROR, 32'h1);
    reg_wr(REG_ERROR, 32'h1);
    i_ctl.issue(CMD_ACT, 3'h1, 15'h0222);
    reg_rd(REG_BANKS, 32'h44);
    // Auto precharge on bank 3, then a read to bank 1 four clocks later
    i_ctl.issue(CMD_READ, 3'h3, 15'h0460);
    reg_rd(REG_BANKS, 32'h84);
    wait_ck(2);
    i_ctl.issue(CMD_READ, 3'h1, 15'h0070);
    wait_ck(10);
    #30;
    check({15'h0, dq_oe, dq}, {15'h0, 1'b1, 16'ha55a ^ {3'h1, 10'h073, 3'h3}});
    reg_rd(REG_ERROR, 32'h0);
    reg_rd(REG_BANKS, 32'h04);
    i_ctl.issue(CMD_PRE, 3'h0, 15'h0400);
    reg_rd(REG_BANKS, 32'haaaa);
    wait_ck(8);
    reg_rd(REG_BANKS, 32'h0);
    i_ctl.issue(CMD_ACT, 3'h2, 15'h0333);
    i_ctl.issue(CMD_PRE, 3'h2, 15'h0);
    reg_rd(REG_BANKS, 32'h20);
    i_ctl.issue(CMD_PRE, 3'h2, 15'h0);
    wait_ck(4);
    reg_rd(REG_BANKS, 32'h20);
    reg_rd(REG_ERROR, 32'h0);
    wait_ck(2);
    reg_rd(REG_BANKS, 32'h0);
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
